// file: include/mot_map.vh
// Register map, field positions and reset values of the modulo overflow timer
`ifndef MOT_MAP_VH
`define MOT_MAP_VH

`define MOT_ADDR_W 4
`define MOT_OFS_STATUS_CONTROL 4'h0
`define MOT_OFS_CLOCK_CONFIG 4'h4
`define MOT_OFS_COUNT_VALUE 4'h8
`define MOT_OFS_MODULO_LIMIT 4'hc

`define MOT_BIT_OVF 7
`define MOT_BIT_IRQ_EN 6
`define MOT_BIT_CNT_RST 5
`define MOT_BIT_HALT 4
`define MOT_SRC_HI 5
`define MOT_SRC_LO 4
`define MOT_PS_HI 3
`define MOT_PS_LO 0

`define MOT_SRC_BUS 2'h0
`define MOT_SRC_FIXED 2'h1
`define MOT_SRC_PIN_FALL 2'h2
`define MOT_SRC_PIN_RISE 2'h3
`define MOT_PS_MAX 4'h8

`define MOT_CNT_RESET 8'h00
`define MOT_MOD_RESET 8'h00
`define MOT_SRC_RESET 2'h0
`define MOT_PS_RESET 4'h0
`define MOT_HALT_RESET 1'b1

`define MOT_RESP_OKAY 2'h0
`define MOT_RESP_SLVERR 2'h2

`endif

// file: verilog/mot_timer.v
// Modulo overflow timer: 8-bit counter, prescaler, source select, AXI4-Lite slave
`timescale 1ns/1ps
`include "mot_map.vh"

// Contract
// (RULE1) Count register is read-only; writes leave the count unchanged.
// (RULE2) Device reset clears the count to zero.
// (RULE3) Modulo register is read/write; zero means free-running.
// (RULE4) Any modulo write clears the count and the overflow flag. Here a wrap in the same cycle keeps the flag set.
// (RULE5) Reset sets modulo to zero so a started counter runs free.
// (RULE6) Modes are stopped, free-running, modulo; stopped after reset.
// (RULE7) Running with nonzero modulo means modulo mode.
// (RULE8) Reset selects bus clock source and divide by one.
// (RULE9) Software starts counting by clearing the halt bit.
// (RULE10) Sources: bus clock, fixed clock, pin rising or falling edge.
// (RULE11) Changing the source keeps the count.
// (RULE12) Prescaler divides by 1 through 256 in powers of two.
// (RULE13) Changing the prescale keeps the count.
// (RULE14) Modulo may be set to any value 1 through 255.
// (RULE15) Count increments per tick until equal to modulo, then wraps to zero.
// (RULE16) Overflow flag sets on the modulo-to-zero transition.
// (RULE17) Flag clears by status read while set, then writing zero.
// (RULE18) Overflow between read and clearing write cancels the clear.
// (RULE19) Writing one to counter-reset also clears the overflow flag. Here a wrap in the same cycle keeps the flag set.
// (RULE20) Interrupt request is flag AND interrupt enable.
// (RULE21) Software clears the flag before setting interrupt enable.
// (RULE22) Counter-reset bit is write-only, one resets, reads zero.
// (RULE23) Halt bit freezes the count; reset sets it.
// (RULE24) Source codes: 00 bus, 01 fixed, 10 pin fall, 11 pin rise.
// (RULE25) Prescale codes 0 to 8 divide by two to the code; above, 256.
// (RULE26) Pin and fixed clock are synchronised and edge detected.
// (RULE27) Free-running wraps from all-ones to zero and sets the flag.
module mot_timer (
  input wire mclk,
  input wire arst_n,
  input wire [`MOT_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`MOT_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire fixed_freq_clock,
  input wire ext_count_pin,
  output reg overflow_irq
);

  // Registers
  reg [7:0] count_reg;
  reg [7:0] modulo_reg;
  reg overflow_flag_reg;
  reg irq_enable_reg;
  reg halt_reg;
  reg [1:0] source_reg;
  reg [3:0] prescale_reg;
  reg [7:0] prescale_cnt_reg;
  reg clear_armed_reg;

  // Three-stage synchronisers; a change counts when stages two and three agree
  reg [2:0] pin_sync_reg;
  reg [2:0] fix_sync_reg;
  reg pin_state_reg;
  reg fix_state_reg;

  // Write channel state
  reg aw_held_reg;
  reg w_held_reg;
  reg [`MOT_ADDR_W-1:0] aw_addr_reg;
  reg [31:0] w_data_reg;
  reg [3:0] w_strb_reg;

  function [7:0] read_mux;
    input [`MOT_ADDR_W-1:0] addr;
    begin
      case (addr)
        `MOT_OFS_STATUS_CONTROL: read_mux = {overflow_flag_reg, irq_enable_reg, 1'b0, // RULE22
          halt_reg, 4'h0};
        `MOT_OFS_CLOCK_CONFIG: read_mux = {2'h0, source_reg, prescale_reg};
        `MOT_OFS_COUNT_VALUE: read_mux = count_reg; // RULE1
        `MOT_OFS_MODULO_LIMIT: read_mux = modulo_reg; // RULE3
        default: read_mux = 8'h00;
      endcase
    end
  endfunction

  function addr_mapped;
    input [`MOT_ADDR_W-1:0] addr;
    begin
      addr_mapped = (addr[1:0] == 2'h0);
    end
  endfunction

  // Register select, shared by the write strobes and the read arming
  function reg_hit;
    input [`MOT_ADDR_W-1:0] addr;
    input [`MOT_ADDR_W-1:0] ofs;
    begin
      reg_hit = (addr == ofs);
    end
  endfunction

  // Pin sampling; the agreed level only moves when two stages match, so a glitch is ignored
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      pin_sync_reg <= 3'h0;
      pin_state_reg <= 1'b0;
    end else begin
      pin_sync_reg <= {pin_sync_reg[1:0], ext_count_pin}; // RULE26
      if (pin_sync_reg[1] == pin_sync_reg[2]) begin
        pin_state_reg <= pin_sync_reg[2];
      end
    end
  end

  // Fixed clock sampling; it must run well below half the bus clock to be seen
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      fix_sync_reg <= 3'h0;
      fix_state_reg <= 1'b0;
    end else begin
      fix_sync_reg <= {fix_sync_reg[1:0], fixed_freq_clock}; // RULE26
      if (fix_sync_reg[1] == fix_sync_reg[2]) begin
        fix_state_reg <= fix_sync_reg[2];
      end
    end
  end

  wire pin_agree = (pin_sync_reg[1] == pin_sync_reg[2]);
  wire fix_agree = (fix_sync_reg[1] == fix_sync_reg[2]);
  wire pin_rise = pin_agree && pin_sync_reg[2] && !pin_state_reg;
  wire pin_fall = pin_agree && !pin_sync_reg[2] && pin_state_reg;
  wire fix_rise = fix_agree && fix_sync_reg[2] && !fix_state_reg;

  reg src_tick;
  always @* begin
    case (source_reg) // RULE10 RULE24
      `MOT_SRC_BUS: src_tick = 1'b1;
      `MOT_SRC_FIXED: src_tick = fix_rise;
      `MOT_SRC_PIN_FALL: src_tick = pin_fall;
      `MOT_SRC_PIN_RISE: src_tick = pin_rise;
      default: src_tick = 1'b1;
    endcase
  end

  // Divider mask: a tick passes when the low code bits of the prescale count are all ones
  reg [7:0] ps_mask;
  always @* begin
    if (prescale_reg >= `MOT_PS_MAX) begin
      ps_mask = 8'hff; // RULE25
    end else begin
      ps_mask = (8'h01 << prescale_reg[2:0]) - 8'h01; // RULE12 RULE25
    end
  end

  wire running = !halt_reg; // RULE6 RULE23
  wire src_en = running && src_tick;
  wire count_tick = src_en && ((prescale_cnt_reg & ps_mask) == ps_mask); // RULE12
  // Modulo zero compares against all ones, which gives the free-running wrap
  wire [7:0] wrap_at = (modulo_reg == 8'h00) ? 8'hff : modulo_reg; // RULE7 RULE27
  wire wrap = count_tick && (count_reg == wrap_at); // RULE15 RULE16

  // Bus decode
  wire aw_have = aw_held_reg || s_axi_awvalid;
  wire w_have = w_held_reg || s_axi_wvalid;
  wire [`MOT_ADDR_W-1:0] wr_addr = aw_held_reg ? aw_addr_reg : s_axi_awaddr;
  wire [31:0] wr_data = w_held_reg ? w_data_reg : s_axi_wdata;
  wire [3:0] wr_strb = w_held_reg ? w_strb_reg : s_axi_wstrb;
  wire do_write = aw_have && w_have && !s_axi_bvalid;
  wire wr_lane0 = do_write && wr_strb[0] && addr_mapped(wr_addr);
  wire wr_sc = wr_lane0 && reg_hit(wr_addr, `MOT_OFS_STATUS_CONTROL);
  wire wr_clk = wr_lane0 && reg_hit(wr_addr, `MOT_OFS_CLOCK_CONFIG);
  wire wr_mod = wr_lane0 && reg_hit(wr_addr, `MOT_OFS_MODULO_LIMIT);
  wire cnt_rst = wr_sc && wr_data[`MOT_BIT_CNT_RST]; // RULE22
  wire do_read = s_axi_arvalid && s_axi_arready;
  wire rd_sc_flag = do_read && reg_hit(s_axi_araddr, `MOT_OFS_STATUS_CONTROL)
    && overflow_flag_reg;
  wire clear_req = wr_sc && !wr_data[`MOT_BIT_OVF] && clear_armed_reg; // RULE17

  // Next-state values of the prescaler, the counter and its flag
  reg [7:0] prescale_cnt_next;
  reg [7:0] count_next;
  reg overflow_flag_next;
  reg clear_armed_next;

  always @* begin
    prescale_cnt_next = prescale_cnt_reg;
    if (src_en) begin
      prescale_cnt_next = prescale_cnt_reg + 8'h01;
    end
  end

  always @* begin
    count_next = count_reg;
    if (wr_mod || cnt_rst) begin
      count_next = `MOT_CNT_RESET; // RULE4 RULE22
    end else if (wrap) begin
      count_next = `MOT_CNT_RESET; // RULE15
    end else if (count_tick) begin
      count_next = count_reg + 8'h01; // RULE15
    end
  end

  // An overflow in the same cycle as a clear wins, so no overflow is ever lost
  always @* begin
    overflow_flag_next = overflow_flag_reg;
    clear_armed_next = clear_armed_reg;
    if (wrap) begin
      overflow_flag_next = 1'b1; // RULE16 RULE18 RULE27
      clear_armed_next = 1'b0; // RULE18
    end else if (wr_mod || cnt_rst || clear_req) begin
      overflow_flag_next = 1'b0; // RULE4 RULE17 RULE19
      clear_armed_next = 1'b0;
    end else if (rd_sc_flag) begin
      clear_armed_next = 1'b1; // RULE17
    end
  end

  // Prescaler is cleared only by reset, so a rate change keeps the count but not the phase
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      prescale_cnt_reg <= 8'h00;
    end else begin
      prescale_cnt_reg <= prescale_cnt_next;
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      count_reg <= `MOT_CNT_RESET; // RULE2
    end else begin
      count_reg <= count_next;
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      overflow_flag_reg <= 1'b0;
      clear_armed_reg <= 1'b0;
    end else begin
      overflow_flag_reg <= overflow_flag_next;
      clear_armed_reg <= clear_armed_next;
    end
  end

  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      modulo_reg <= `MOT_MOD_RESET; // RULE5
    end else if (wr_mod) begin
      modulo_reg <= wr_data[7:0]; // RULE3 RULE14
    end
  end

  // Source and prescale changes never touch the count
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      source_reg <= `MOT_SRC_RESET; // RULE8
      prescale_reg <= `MOT_PS_RESET; // RULE8
    end else if (wr_clk) begin
      source_reg <= wr_data[`MOT_SRC_HI:`MOT_SRC_LO]; // RULE11
      prescale_reg <= wr_data[`MOT_PS_HI:`MOT_PS_LO]; // RULE13
    end
  end

  // Halt and interrupt enable are written together by any status write
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      halt_reg <= `MOT_HALT_RESET; // RULE6 RULE23
      irq_enable_reg <= 1'b0;
    end else if (wr_sc) begin
      irq_enable_reg <= wr_data[`MOT_BIT_IRQ_EN];
      halt_reg <= wr_data[`MOT_BIT_HALT]; // RULE9 RULE23
    end
  end

  // Registered so the interrupt output comes from a flip-flop
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      overflow_irq <= 1'b0;
    end else begin
      overflow_irq <= overflow_flag_reg && irq_enable_reg; // RULE20
    end
  end

  // AXI4-Lite write address channel: address and data accepted in either order
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      aw_held_reg <= 1'b0;
      aw_addr_reg <= {`MOT_ADDR_W{1'b0}};
      s_axi_awready <= 1'b1;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (do_write) begin
        aw_held_reg <= 1'b0;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_awready <= 1'b1;
      end
    end
  end

  // Write data channel; ready stays low until the response is taken
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      w_held_reg <= 1'b0;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      s_axi_wready <= 1'b1;
    end else begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        w_held_reg <= 1'b0;
        s_axi_wready <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_wready <= 1'b1;
      end
    end
  end

  // Write response channel
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MOT_RESP_OKAY;
    end else begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_mapped(wr_addr) ? `MOT_RESP_OKAY : `MOT_RESP_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // AXI4-Lite read path
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `MOT_RESP_OKAY;
    end else begin
      if (do_read) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= {24'h000000, read_mux(s_axi_araddr)};
        s_axi_rresp <= addr_mapped(s_axi_araddr) ? `MOT_RESP_OKAY : `MOT_RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

endmodule // mot_timer

// file: test/mot_timer_asserts.sv
// Bus answer and flag checks for the modulo overflow timer
`timescale 1ns/1ps
`include "mot_map.vh"
module mot_timer_asserts (
  input wire mclk,
  input wire arst_n,
  input wire [`MOT_ADDR_W-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [`MOT_ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire overflow_irq
);
  logic [`MOT_ADDR_W-1:0] aw_reg;
  logic [`MOT_ADDR_W-1:0] ar_reg;
  // Addresses held so each answer can be judged by its target
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      aw_reg <= '0;
      ar_reg <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) aw_reg <= s_axi_awaddr;
      if (s_axi_arvalid && s_axi_arready) ar_reg <= s_axi_araddr;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!arst_n);
  reset_idle_a:
    assert property ($rose(arst_n) |-> s_axi_awready && s_axi_arready && !s_axi_bvalid
      && !s_axi_rvalid && !overflow_irq) else $error("busy after reset");
  wr_answer_a:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid) else $error("write not answered");
  rd_answer_a:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read not answered");
  b_hold_a:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
  r_hold_a:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
  bad_wr_a:
    assert property ($rose(s_axi_bvalid) && aw_reg[1:0] != 2'h0
      |-> s_axi_bresp == `MOT_RESP_SLVERR) else $error("bad write accepted");
  bad_rd_a:
    assert property ($rose(s_axi_rvalid) && ar_reg[1:0] != 2'h0
      |-> s_axi_rresp == `MOT_RESP_SLVERR && s_axi_rdata == 32'h0) else $error("bad read");
  ctl_rsvd_a:
    assert property (s_axi_rvalid && ar_reg == `MOT_OFS_STATUS_CONTROL |-> !s_axi_rdata[5]
      && s_axi_rdata[3:0] == 4'h0 && s_axi_rdata[31:8] == 24'h0) else $error("status bits");
  cnt_width_a:
    assert property (s_axi_rvalid && ar_reg == `MOT_OFS_COUNT_VALUE
      |-> s_axi_rdata[31:8] == 24'h0) else $error("count wider than 8 bits");
  irq_match_a:
    assert property ($rose(s_axi_rvalid) && ar_reg == `MOT_OFS_STATUS_CONTROL
      && s_axi_rdata[7:6] == 2'h3 |-> ##[0:1] overflow_irq) else $error("irq missing");
endmodule // mot_timer_asserts
bind mot_timer mot_timer_asserts u_chk (.mclk, .arst_n, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .overflow_irq);

// file: test/testbench.sv
// Self-checking bench for the modulo overflow timer
`timescale 1ns/1ps
`include "mot_map.vh"
module testbench;
  localparam logic [3:0] SC = `MOT_OFS_STATUS_CONTROL;
  localparam logic [3:0] CK = `MOT_OFS_CLOCK_CONFIG;
  localparam logic [3:0] CN = `MOT_OFS_COUNT_VALUE;
  localparam logic [3:0] MD = `MOT_OFS_MODULO_LIMIT;
  logic mclk = 0, arst_n = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0, fixed_freq_clock = 0, ext_count_pin = 0;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 0, rv;
  logic [1:0] rs;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, overflow_irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  int err_total = 0, n_checks = 0;
  mot_timer DUT (.mclk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .fixed_freq_clock, .ext_count_pin,
    .overflow_irq);
  initial forever #2 mclk = ~mclk;
  task finish_test;
    if (err_total == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      $display("[ERR] %0t got %h exp %h", $time, g, e);
      err_total++;
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task to(input int i);
    if (i == 60) begin
      err_total++;
      finish_test();
    end
  endtask
  // Ready is raised a cycle late on purpose so the slave must hold its answer
  task wr(input logic [3:0] a, input logic [7:0] d);
    int i;
    @(posedge mclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    for (i = 0; i < 60; i++) begin
      @(posedge mclk);
      if (s_axi_awready) s_axi_awvalid <= 0;
      if (s_axi_wready) s_axi_wvalid <= 0;
      if (s_axi_bvalid && s_axi_bready) break;
      s_axi_bready <= i > 0;
    end
    rs = s_axi_bresp;
    s_axi_bready <= 0;
    to(i);
  endtask
  task rd(input logic [3:0] a);
    int i;
    @(posedge mclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    for (i = 0; i < 60; i++) begin
      @(posedge mclk);
      if (s_axi_arready) s_axi_arvalid <= 0;
      if (s_axi_rvalid && s_axi_rready) break;
      s_axi_rready <= i > 0;
    end
    rv = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 0;
    to(i);
  endtask
  task rc(input logic [3:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
  endtask
  task t_reset;
    rc(SC, 32'h10);
    rc(CK, 32'h0);
    rc(CN, 32'h0);
    rc(MD, 32'h0);
  endtask
  task t_bus;
    wr(MD, 8'hff);
    rc(MD, 32'hff);
    wr(CN, 8'h55);
    rc(CN, 32'h0);
    wr(4'h2, 8'h01);
    chk(rs, `MOT_RESP_SLVERR);
    rd(4'h3);
    chk(rs, `MOT_RESP_SLVERR);
  endtask
  task t_flag;
    wr(MD, 8'h01);
    wr(SC, 8'h00);
    cyc(20);
    wr(SC, 8'h10);
    rc(SC, 32'h90);
    rd(CN);
    chk(rv[31:1], 0);
    wr(SC, 8'h10);
    rc(SC, 32'h10);
    wr(SC, 8'h00);
    cyc(10);
    rc(SC, 32'h80);
    cyc(10);
    wr(SC, 8'h10);
    rc(SC, 32'h90);
  endtask
  task t_irq;
    wr(SC, 8'h10);
    wr(SC, 8'h40);
    cyc(10);
    chk(overflow_irq, 1);
    rc(SC, 32'hc0);
    wr(SC, 8'h10);
    cyc(2);
    chk(overflow_irq, 0);
  endtask
  task t_mod;
    logic [31:0] c;
    wr(MD, 8'h00);
    rc(SC, 32'h10);
    rc(CN, 32'h0);
    wr(SC, 8'h00);
    cyc(300);
    wr(SC, 8'h10);
    rc(SC, 32'h90);
    rd(CN);
    c = rv;
    cyc(5);
    rc(CN, c);
    wr(SC, 8'h00);
    wr(CK, 8'h19);
    wr(SC, 8'h10);
    rd(CN);
    chk(rv >= c && rv < c + 20, 1);
    wr(SC, 8'h30);
    rc(SC, 32'h10);
    rc(CN, 32'h0);
  endtask
  // Window is about 44 bus cycles; bounds allow for prescaler phase
  task t_pre(input logic [7:0] cfg, input int lo, input int hi);
    wr(MD, 8'h00);
    wr(CK, cfg);
    wr(SC, 8'h00);
    cyc(40);
    wr(SC, 8'h10);
    rd(CN);
    chk(rv >= lo && rv <= hi, 1);
  endtask
  // Pin gives 5 rises and 4 falls, the fixed clock 3 rises
  task t_src(input logic [7:0] cfg, input logic [31:0] e);
    ext_count_pin <= 0;
    wr(MD, 8'h00);
    wr(CK, cfg);
    wr(SC, 8'h00);
    for (int i = 0; i < 5; i++) begin
      ext_count_pin <= 0;
      fixed_freq_clock <= 0;
      cyc(8);
      ext_count_pin <= 1;
      fixed_freq_clock <= i < 3;
      cyc(8);
    end
    wr(SC, 8'h10);
    rc(CN, e);
  endtask
  initial begin
    cyc(2);
    arst_n <= 1;
    t_reset();
    t_bus();
    t_flag();
    t_irq();
    t_mod();
    t_pre(8'h00, 40, 48);
    t_pre(8'h02, 9, 13);
    t_pre(8'h09, 0, 1);
    t_src(8'h10, 3);
    t_src(8'h20, 4);
    t_src(8'h30, 5);
    finish_test();
  end
endmodule // testbench
